// [shared/cen_pkg.sv]
// Constants, types and register map of the camera event notifier.
package cen_pkg;

    localparam int unsigned CEN_NUM_EVENTS = 9;
    localparam int unsigned CEN_TS_WIDTH = 32;
    localparam int unsigned CEN_ADDR_WIDTH = 6;

    // Register byte offsets.
    localparam logic [5:0] CEN_OFS_SELECT = 6'h00;
    localparam logic [5:0] CEN_OFS_ENABLE = 6'h04;
    localparam logic [5:0] CEN_OFS_STATUS = 6'h08;
    localparam logic [5:0] CEN_OFS_MASK = 6'h0C;
    localparam logic [5:0] CEN_OFS_DROPPED = 6'h10;
    localparam logic [5:0] CEN_OFS_TS_BASE = 6'h14;

    // Reset values.
    localparam logic [3:0] CEN_SELECT_RST = 4'h0;
    localparam logic [8:0] CEN_ENABLE_RST = 9'h000;
    localparam logic [1:0] CEN_MASK_RST = 2'h0;

    // Interrupt status bit positions.
    localparam int unsigned CEN_IRQ_SENT = 0;
    localparam int unsigned CEN_IRQ_DROP = 1;

    typedef enum logic [3:0] {
        CEN_EV_ACCEPTED = 4'h0,
        CEN_EV_REJECTED = 4'h1,
        CEN_EV_AWAITING = 4'h2,
        CEN_EV_SEND_BEGIN = 4'h3,
        CEN_EV_SEND_FINISH = 4'h4,
        CEN_EV_EXP_BEGIN = 4'h5,
        CEN_EV_EXP_FINISH = 4'h6,
        CEN_EV_TMR_BEGIN = 4'h7,
        CEN_EV_TMR_FINISH = 4'h8
    } cen_event_e;

    localparam logic [15:0] CEN_ID_ACCEPTED = 16'h8020;
    localparam logic [15:0] CEN_ID_REJECTED = 16'h8021;
    localparam logic [15:0] CEN_ID_AWAITING = 16'h8022;
    localparam logic [15:0] CEN_ID_SEND_BEGIN = 16'h8030;
    localparam logic [15:0] CEN_ID_SEND_FINISH = 16'h8031;
    localparam logic [15:0] CEN_ID_EXP_BEGIN = 16'h8040;
    localparam logic [15:0] CEN_ID_EXP_FINISH = 16'h8041;
    localparam logic [15:0] CEN_ID_TMR_BEGIN = 16'h9000;
    localparam logic [15:0] CEN_ID_TMR_FINISH = 16'h9100;

    // Software register request.
    typedef struct packed {
        logic [5:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } cen_reg_req_s;

    // One event message toward the host.
    typedef struct packed {
        logic [15:0] id;
        logic [31:0] timestamp;
    } cen_msg_s;

endpackage

// [design/cen_ts_store.sv]
`timescale 1ns/1ps
// Per-type timestamp store with registered read data.
module cen_ts_store
    import cen_pkg::*;
#(
    parameter int unsigned DEPTH = 9,
    parameter int unsigned WIDTH = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write side, one bit per entry
    input wire logic [DEPTH-1:0] wr_en_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    // Read side
    input wire logic [3:0] rd_idx_i,
    output logic [WIDTH-1:0] rd_data_o
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_entry
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    mem_q[g] <= '0;
                end else if (wr_en_i[g]) begin
                    mem_q[g] <= wr_data_i;
                end
            end
        end
    endgenerate

    wire logic rd_hit = 32'(rd_idx_i) < DEPTH;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= rd_hit ? mem_q[rd_idx_i] : '0;
        end
    end

endmodule

// [design/cen_notifier.sv]
`timescale 1ns/1ps
// Camera event notifier: timestamps milestones and emits event messages.
module cen_notifier
    import cen_pkg::*;
#(
    parameter int unsigned TS_WIDTH = CEN_TS_WIDTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Acquisition milestones, one-cycle pulses in type order
    input wire logic [CEN_NUM_EVENTS-1:0] event_pulse_i,
    // Register port
    input wire logic [CEN_ADDR_WIDTH-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Event message channel toward the host
    output logic msg_valid_o,
    output logic [15:0] msg_id_o,
    output logic [TS_WIDTH-1:0] msg_ts_o,
    input wire logic msg_ready_i,
    // Interrupt
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Register decode.

    cen_reg_req_s req;
    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    wire logic hit_select = req.addr == CEN_OFS_SELECT;
    wire logic hit_enable = req.addr == CEN_OFS_ENABLE;
    wire logic hit_status = req.addr == CEN_OFS_STATUS;
    wire logic hit_mask = req.addr == CEN_OFS_MASK;
    wire logic hit_dropped = req.addr == CEN_OFS_DROPPED;
    wire logic [5:0] ts_off = req.addr - CEN_OFS_TS_BASE;
    wire logic hit_ts = req.addr >= CEN_OFS_TS_BASE && ts_off[1:0] == 2'h0 && ts_off[5:2] < 4'(CEN_NUM_EVENTS);

    logic [3:0] select_q;
    logic [CEN_NUM_EVENTS-1:0] enable_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic [15:0] dropped_q;

    // Only legal type codes are accepted, so the selector never names a missing type.
    wire logic select_ok = req.wdata[31:4] == 28'h0 && req.wdata[3:0] < 4'(CEN_NUM_EVENTS);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            select_q <= CEN_SELECT_RST;
        end else if (req.wr && hit_select && select_ok) begin
            select_q <= req.wdata[3:0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            enable_q <= CEN_ENABLE_RST;
        end else if (req.wr && hit_enable) begin
            enable_q[select_q] <= req.wdata[0];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mask_q <= CEN_MASK_RST;
        end else if (req.wr && hit_mask) begin
            mask_q <= req.wdata[1:0];
        end
    end

    // The interrupt flop looks at the mask it will hold, so a mask write moves the line in the same edge.
    wire logic [1:0] mask_d = (req.wr && hit_mask) ? req.wdata[1:0] : mask_q;

    ////////////////////////////////////////////////////////////////////////////
    // Timestamps.

    logic [TS_WIDTH-1:0] time_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            time_q <= '0;
        end else begin
            time_q <= time_q + 1'b1;
        end
    end

    logic [TS_WIDTH-1:0] ts_rdata;

    cen_ts_store #(
        .DEPTH(CEN_NUM_EVENTS),
        .WIDTH(TS_WIDTH)
    ) u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_en_i(event_pulse_i),
        .wr_data_i(time_q),
        .rd_idx_i(ts_off[5:2]),
        .rd_data_o(ts_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event capture and message arbitration.

    // Occurrences wait here until loaded into the message slot; a repeat before that counts as dropped.
    logic [CEN_NUM_EVENTS-1:0] pend_q;
    logic [TS_WIDTH-1:0] pend_ts_q [CEN_NUM_EVENTS];
    wire logic [CEN_NUM_EVENTS-1:0] fire = event_pulse_i & enable_q;

    logic [15:0] id_tab [CEN_NUM_EVENTS];
    assign id_tab[CEN_EV_ACCEPTED] = CEN_ID_ACCEPTED;
    assign id_tab[CEN_EV_REJECTED] = CEN_ID_REJECTED;
    assign id_tab[CEN_EV_AWAITING] = CEN_ID_AWAITING;
    assign id_tab[CEN_EV_SEND_BEGIN] = CEN_ID_SEND_BEGIN;
    assign id_tab[CEN_EV_SEND_FINISH] = CEN_ID_SEND_FINISH;
    assign id_tab[CEN_EV_EXP_BEGIN] = CEN_ID_EXP_BEGIN;
    assign id_tab[CEN_EV_EXP_FINISH] = CEN_ID_EXP_FINISH;
    assign id_tab[CEN_EV_TMR_BEGIN] = CEN_ID_TMR_BEGIN;
    assign id_tab[CEN_EV_TMR_FINISH] = CEN_ID_TMR_FINISH;

    // Lowest type number wins when several are pending.
    logic [3:0] pick;
    logic pick_any;
    always_comb begin
        pick = 4'h0;
        pick_any = 1'b0;
        for (int i = CEN_NUM_EVENTS - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                pick = 4'(i);
                pick_any = 1'b1;
            end
        end
    end

    wire logic slot_free = !msg_valid_o || msg_ready_i;
    wire logic load = slot_free && pick_any;
    wire logic [CEN_NUM_EVENTS-1:0] taken = load ? (CEN_NUM_EVENTS'(1) << pick) : '0;
    wire logic any_drop = |(fire & pend_q & ~taken);

    genvar g;
    generate
        for (g = 0; g < CEN_NUM_EVENTS; g++) begin : g_pend
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    pend_q[g] <= 1'b0;
                    pend_ts_q[g] <= '0;
                end else begin
                    // A new occurrence in the cycle its predecessor is taken stays pending.
                    pend_q[g] <= fire[g] | (pend_q[g] & ~taken[g]);
                    if (fire[g]) begin
                        pend_ts_q[g] <= time_q;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            msg_valid_o <= 1'b0;
            msg_id_o <= '0;
            msg_ts_o <= '0;
        end else if (slot_free) begin
            msg_valid_o <= pick_any;
            msg_id_o <= pick_any ? id_tab[pick] : '0;
            msg_ts_o <= pick_any ? pend_ts_q[pick] : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status; a hardware set wins over a software clear.

    wire logic sent = msg_valid_o && msg_ready_i;
    wire logic [1:0] st_set = {any_drop, sent};
    wire logic [1:0] st_clr = (req.wr && hit_status) ? req.wdata[1:0] : 2'h0;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_q <= 2'h0;
            dropped_q <= '0;
            irq_o <= 1'b0;
        end else begin
            status_q <= st_set | (status_q & ~st_clr);
            irq_o <= |((st_set | (status_q & ~st_clr)) & mask_d);
            if (any_drop && dropped_q != 16'hFFFF) begin
                dropped_q <= dropped_q + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, valid one cycle after the read strobe.

    logic rd_ts_q;
    logic [31:0] rd_reg_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ts_q <= 1'b0;
            rd_reg_q <= '0;
        end else begin
            rd_ts_q <= req.rd && hit_ts;
            rd_reg_q <= '0;
            if (req.rd) begin
                unique case (1'b1)
                    hit_select: rd_reg_q <= {28'h0, select_q};
                    hit_enable: rd_reg_q <= {31'h0, enable_q[select_q]};
                    hit_status: rd_reg_q <= {30'h0, status_q};
                    hit_mask: rd_reg_q <= {30'h0, mask_q};
                    hit_dropped: rd_reg_q <= {16'h0, dropped_q};
                    default: rd_reg_q <= '0;
                endcase
            end
        end
    end

    // The timestamp store already registers its data, so the mux stays combinational here.
    always_comb begin
        reg_rdata_o = rd_ts_q ? 32'(ts_rdata) : rd_reg_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    accepted_id_a: assert property (@(posedge clk_i) disable iff (rst_i)
        msg_valid_o && msg_id_o == CEN_ID_ACCEPTED |-> $past(pend_q[0], 1) || $past(msg_valid_o))
        else $error("accepted message without pending accepted event");
    disabled_silent_a: assert property (@(posedge clk_i) disable iff (rst_i)
        event_pulse_i[0] && !enable_q[0] && !pend_q[0] |=> !pend_q[0])
        else $error("disabled type became pending");
    enabled_pend_a: assert property (@(posedge clk_i) disable iff (rst_i)
        |fire |=> |pend_q || msg_valid_o)
        else $error("enabled event lost");
    msg_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        msg_valid_o && !msg_ready_i |=> msg_valid_o && $stable(msg_id_o) && $stable(msg_ts_o))
        else $error("message changed while stalled");
    ts_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        event_pulse_i[3] |=> u_store.mem_q[3] == time_q - 1'b1)
        else $error("timestamp not latched from counter");
    ts_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !event_pulse_i[6] |=> $stable(u_store.mem_q[6]))
        else $error("timestamp changed without event");
    select_legal_a: assert property (@(posedge clk_i) disable iff (rst_i)
        select_q < 4'(CEN_NUM_EVENTS))
        else $error("selector out of range");
    enable_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        req.wr && hit_enable |=> enable_q[$past(select_q)] == $past(req.wdata[0]))
        else $error("switch write missed selected type");
    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o == |(status_q & mask_q))
        else $error("interrupt level differs from unmasked status");

endmodule

// [bench/cen_host_model.sv]
// Host-side model that accepts event messages and logs each one it takes.
`timescale 1ns/1ps
module cen_host_model
    import cen_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Message channel
    input wire logic msg_valid_i,
    input wire logic [15:0] msg_id_i,
    input wire logic [31:0] msg_ts_i,
    output logic msg_ready_o,
    // Back-pressure control
    input wire logic stall_i
);
    logic [15:0] id_q[$];
    logic [31:0] ts_q[$];

    // The host refuses only while stalled, so a held message must survive the wait.
    assign msg_ready_o = !stall_i;

    always @(posedge clk_i) begin
        if (!rst_i && msg_valid_i && msg_ready_o) begin
            id_q.push_back(msg_id_i);
            ts_q.push_back(msg_ts_i);
        end
    end
endmodule

// [bench/tb.sv]
// Register and event-channel testbench of the camera event notifier.
`timescale 1ns/1ps
module tb;
    import cen_pkg::*;

    localparam logic [15:0] IDS [9] = '{CEN_ID_ACCEPTED, CEN_ID_REJECTED, CEN_ID_AWAITING, CEN_ID_SEND_BEGIN,
        CEN_ID_SEND_FINISH, CEN_ID_EXP_BEGIN, CEN_ID_EXP_FINISH, CEN_ID_TMR_BEGIN, CEN_ID_TMR_FINISH};

    logic clk_i, rst_i, reg_wr_i, reg_rd_i, stall, msg_ready, msg_valid, irq;
    logic [8:0] event_pulse_i;
    logic [5:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata, msg_ts;
    logic [15:0] msg_id;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc = 0;

    cen_notifier u_cen_notifier (.clk_i(clk_i), .rst_i(rst_i), .event_pulse_i(event_pulse_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata), .msg_valid_o(msg_valid), .msg_id_o(msg_id), .msg_ts_o(msg_ts),
        .msg_ready_i(msg_ready), .irq_o(irq));

    cen_host_model u_cen_host_model (.clk_i(clk_i), .rst_i(rst_i), .msg_valid_i(msg_valid), .msg_id_i(msg_id),
        .msg_ts_i(msg_ts), .msg_ready_o(msg_ready), .stall_i(stall));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are sampled just past that edge.
    task automatic rdc(input string name, input logic [5:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check(name, reg_rdata, exp);
    endtask

    task automatic pulse(input logic [8:0] m, output int t);
        @(posedge clk_i);
        event_pulse_i <= m;
        @(posedge clk_i);
        t = cyc;
        event_pulse_i <= '0;
    endtask

    task automatic wait_msgs(input int n);
        for (int i = 0; i < 40 && u_cen_host_model.id_q.size() < n; i++) @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int t[9];
        int td;
        int t3;
        int tb1;
        logic ia;
        logic ib;
        rst_i = 1'b1;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = '0;
        reg_wdata_i = '0;
        event_pulse_i = '0;
        stall = 1'b0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc("select_rst", CEN_OFS_SELECT, 32'h0);
        rdc("enable_rst", CEN_OFS_ENABLE, 32'h0);
        rdc("status_rst", CEN_OFS_STATUS, 32'h0);
        rdc("mask_rst", CEN_OFS_MASK, 32'h0);
        rdc("dropped_rst", CEN_OFS_DROPPED, 32'h0);
        rdc("unmapped", 6'h38, 32'h0);
        // Nothing may leave while every switch is still Off.
        pulse(9'h001, td);
        repeat (4) @(posedge clk_i);
        check("quiet_count", 32'(u_cen_host_model.id_q.size()), 32'h0);
        for (int n = 0; n < 9; n++) begin
            wr(CEN_OFS_SELECT, 32'(n));
            rdc("select", CEN_OFS_SELECT, 32'(n));
            wr(CEN_OFS_ENABLE, 32'h1);
            rdc("enable", CEN_OFS_ENABLE, 32'h1);
            pulse(9'(1 << n), t[n]);
            wait_msgs(n + 1);
            check("msg_id", 32'(u_cen_host_model.id_q[n]), 32'(IDS[n]));
        end
        for (int n = 0; n < 9; n++) begin
            check("ts_step", u_cen_host_model.ts_q[n] - u_cen_host_model.ts_q[0], 32'(t[n] - t[0]));
            rdc("ts_reg", CEN_OFS_TS_BASE + 6'(4 * n), u_cen_host_model.ts_q[n]);
        end
        // A switched-off type stays silent but still stamps its time.
        wr(CEN_OFS_SELECT, 32'h3);
        wr(CEN_OFS_ENABLE, 32'h0);
        rdc("enable_off", CEN_OFS_ENABLE, 32'h0);
        wr(CEN_OFS_SELECT, 32'h0);
        rdc("enable_other", CEN_OFS_ENABLE, 32'h1);
        pulse(9'h008, t3);
        repeat (4) @(posedge clk_i);
        check("off_count", 32'(u_cen_host_model.id_q.size()), 32'h9);
        rdc("ts_off", CEN_OFS_TS_BASE + 6'hC, u_cen_host_model.ts_q[0] + 32'(t3 - t[0]));
        wr(CEN_OFS_SELECT, 32'h9);
        rdc("select_bad", CEN_OFS_SELECT, 32'h0);
        // Stalled host: two pending types, one repeated before it could leave.
        @(posedge clk_i);
        stall <= 1'b1;
        pulse(9'h022, td);
        pulse(9'h020, tb1);
        repeat (3) @(posedge clk_i);
        check("stall_count", 32'(u_cen_host_model.id_q.size()), 32'h9);
        rdc("dropped", CEN_OFS_DROPPED, 32'h1);
        @(posedge clk_i);
        stall <= 1'b0;
        wait_msgs(11);
        check("order_first", 32'(u_cen_host_model.id_q[9]), 32'(CEN_ID_REJECTED));
        check("order_second", 32'(u_cen_host_model.id_q[10]), 32'(CEN_ID_EXP_BEGIN));
        check("ts_repeat", u_cen_host_model.ts_q[10] - u_cen_host_model.ts_q[0], 32'(tb1 - t[0]));
        // Interrupt: both status bits set, the mask decides, a write of ones clears.
        rdc("status", CEN_OFS_STATUS, 32'h3);
        repeat (2) @(posedge clk_i);
        #1;
        ia = irq;
        wr(CEN_OFS_MASK, 32'h3);
        rdc("mask", CEN_OFS_MASK, 32'h3);
        #1;
        ib = irq;
        check("irq_masked", 32'(ia), 32'h0);
        check("irq_unmasked", 32'(ib), 32'h1);
        wr(CEN_OFS_STATUS, 32'h3);
        repeat (2) @(posedge clk_i);
        #1;
        check("irq_clear", 32'(irq), 32'h0);
        rdc("status_clr", CEN_OFS_STATUS, 32'h0);
        give_verdict();
    end

    // The sequence needs a few hundred cycles; a hang is cut off well beyond that.
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        give_verdict();
    end
endmodule
